// ===== rtl/opc_pkg.sv
/*
  Package for the output driver power control block: register offsets,
  field positions, reset values, timing counts and state encodings.
  Assumes a 250 MHz clock and an APB register bus with 32-bit data.
*/
// Behaviour
// (RULE1) Software writes output configuration type before powering drivers.
// (RULE2) Power-up delay programmable from zero to four seconds.
// (RULE3) Lowest-power down option tri-states pins, removes stage power.
// (RULE4) Second down option weakly holds pins at common-mode, reference alive.
// (RULE5) Third down option holds pins near half supply by divider.
// (RULE6) Down pin condition chosen by pop reduction register field.
// (RULE7) Soft stepping powers up attenuated, then steps down to target level.
// (RULE8) Soft stepping enabled after reset, switchable in output stage control.
// (RULE9) Default mode limits current, reports per-driver protection status.
// (RULE10) Automatic shutdown powers down a shorted driver at once.
// (RULE11) Shut driver stays off, flagged, until software cycles its power.
// (RULE12) Every control register is eight bits, bit seven most significant; the level register here holds 16 bits.
// (RULE13) Page zero location zero selects the register page.
// (RULE14) Software never sets configuration bits six and three together.
// (RULE15) Software restores routing and volume by direct register writes.
// (RULE16) Direct converter path only when no mixing or fan-out needed.
// (RULE17) Each driver has output level gain of up to nine decibels.
// (RULE18) Short status and shutdown latch held per driver.
package opc_pkg;

  localparam int NDRV = 4;
  // Register indices; the bus byte address is four times the index
  localparam logic [7:0] IDX_PAGE   = 8'h00;
  localparam logic [7:0] IDX_OUTCFG = 8'h0E;
  localparam logic [7:0] IDX_STAGE  = 8'h28;
  localparam logic [7:0] IDX_POP    = 8'h2A;
  localparam logic [7:0] IDX_SHORT  = 8'h5F;
  localparam logic [7:0] IDX_POWER  = 8'h60;
  localparam logic [7:0] IDX_LEVEL  = 8'h61;
  localparam logic [7:0] IDX_IRQST  = 8'h62;
  localparam logic [7:0] IDX_IRQMSK = 8'h63;
  localparam logic [7:0] IDX_PWRST  = 8'h64;

  // Field positions
  localparam int POP_DLY_LSB  = 4;   // [7:4] power-up delay code
  localparam int POP_DN_LSB   = 2;   // [3:2] powered-down pin condition
  localparam int STG_SOFT_BIT = 0;   // 0 = soft stepping enabled
  localparam int STG_AUTO_BIT = 1;   // 1 = automatic short shutdown
  localparam int LVL_W        = 4;   // output level code 0..9 dB

  // Reset values
  localparam logic [7:0] RST_PAGE   = 8'h00;
  localparam logic [7:0] RST_OUTCFG = 8'h00;
  localparam logic [7:0] RST_STAGE  = 8'h00;
  localparam logic [7:0] RST_POP    = 8'h00;
  localparam logic [7:0] RST_POWER  = 8'h00;
  localparam logic [7:0] RST_LEVEL  = 8'h00;
  localparam logic [7:0] RST_IRQMSK = 8'h00;

  // Timing: 250 MHz, 1 ms tick
  localparam int CLK_MHZ      = 250;
  localparam int TICK_US      = 1000;
  localparam int TICK_CYC     = CLK_MHZ * TICK_US;
  localparam int STEP_MS      = 1;    // one soft step per millisecond
  localparam int SOFT_START   = 15;   // heavy attenuation, in level steps
  localparam int LEVEL_MAX    = 9;

  // Down-state pin conditions
  typedef enum logic [1:0] {
    OPC_DN_TRISTATE = 2'b00,
    OPC_DN_VCM      = 2'b01,
    OPC_DN_HALF     = 2'b10
  } opc_dn_e;

  // Per-driver sequencer states (Gray along off -> wait -> ramp -> on)
  typedef enum logic [1:0] {
    OPC_OFF  = 2'b00,
    OPC_WAIT = 2'b01,
    OPC_RAMP = 2'b11,
    OPC_ON   = 2'b10
  } opc_state_e;

  // Delay in milliseconds for each code, zero up to four seconds
  function automatic logic [11:0] dly_ms(input logic [3:0] code);
    logic [11:0] t;
    t = 12'h000;
    case (code)
      4'h0: t = 12'd0;
      4'h1: t = 12'd1;
      4'h2: t = 12'd5;
      4'h3: t = 12'd10;
      4'h4: t = 12'd20;
      4'h5: t = 12'd50;
      4'h6: t = 12'd100;
      4'h7: t = 12'd200;
      4'h8: t = 12'd400;
      4'h9: t = 12'd800;
      4'hA: t = 12'd1000;
      4'hB: t = 12'd2000;
      default: t = 12'd4000;
    endcase
    return t;
  endfunction

endpackage

// ===== rtl/opc_drv_if.sv
/*
  Interface joining the register block to the per-driver sequencer.
  Assumes both ends share clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
interface opc_drv_if;
  logic       power_req;
  logic       auto_off;
  logic       soft_en;
  logic [3:0] dly_code;
  logic [3:0] level;
  logic       tick;
  logic       short_det;
  logic       in_prot;
  logic       latched;
  logic       powered;
  logic [3:0] atten;
  modport ctl (output power_req, auto_off, soft_en, dly_code, level, tick, short_det,
               input in_prot, latched, powered, atten);
  modport seq (input power_req, auto_off, soft_en, dly_code, level, tick, short_det,
               output in_prot, latched, powered, atten);
endinterface
`default_nettype wire

// ===== rtl/opc_seq.sv
/*
  One high-power driver's power sequencer: delay, soft ramp and short latch.
  Assumes a 1 ms tick pulse and a short-detect level from the analog stage.
*/
`timescale 1ns/1ps
`default_nettype none
module opc_seq
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  opc_drv_if.seq    d
);
  opc_pkg::opc_state_e state_q;
  logic [11:0]         cnt_q;
  logic [3:0]          att_q;
  logic                lat_q;
  logic                seen_off_q;

  // (RULE9) protection reported per driver
  assign d.in_prot = d.short_det & (state_q != opc_pkg::OPC_OFF);
  assign d.latched = lat_q;
  assign d.powered = (state_q != opc_pkg::OPC_OFF);
  assign d.atten   = att_q;

  // (RULE10) (RULE11) (RULE18) latch per driver, cleared by power cycle
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      lat_q      <= 1'b0;
      seen_off_q <= 1'b0;
    end
    else if (d.auto_off && d.in_prot)
    begin
      lat_q      <= 1'b1;
      seen_off_q <= 1'b0;
    end
    else if (lat_q && !d.power_req)
      seen_off_q <= 1'b1;
    else if (lat_q && seen_off_q && d.power_req)
      lat_q <= 1'b0;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= opc_pkg::OPC_OFF;
      cnt_q   <= 12'h000;
      att_q   <= 4'hF;
    end
    else if (!d.power_req || lat_q || (d.auto_off && d.in_prot))
    begin
      state_q <= opc_pkg::OPC_OFF;
      cnt_q   <= 12'h000;
      att_q   <= 4'hF;
    end
    else
    begin
      case (state_q)
        opc_pkg::OPC_OFF:
        begin
          state_q <= opc_pkg::OPC_WAIT;
          cnt_q   <= opc_pkg::dly_ms(d.dly_code);
        end
        // (RULE2) programmable delay before drive
        opc_pkg::OPC_WAIT:
          if (cnt_q == 12'h000)
          begin
            state_q <= d.soft_en ? opc_pkg::OPC_RAMP : opc_pkg::OPC_ON;
            att_q   <= d.soft_en ? 4'(opc_pkg::SOFT_START) : 4'h0;
          end
          else if (d.tick)
            cnt_q <= cnt_q - 12'h001;
        // (RULE7) step attenuation down each tick
        opc_pkg::OPC_RAMP:
          if (att_q == 4'h0)
            state_q <= opc_pkg::OPC_ON;
          else if (d.tick)
            att_q <= att_q - 4'h1;
        default:
          att_q <= 4'h0;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== rtl/opc_top.sv
/*
  Output driver power control: APB register file, paged map, four driver
  sequencers, pin condition outputs and a masked sticky interrupt.
  Assumes APB3 master on clk_i; short detect inputs synchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module opc_top
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic [3:0]  short_det_i,
  output logic      [3:0]  drv_enable_o,
  output logic      [3:0]  drv_tristate_o,
  output logic      [3:0]  hold_vcm_o,
  output logic      [3:0]  hold_half_o,
  output logic             ref_keep_o,
  output logic      [15:0] drv_gain_o,
  output logic      [15:0] drv_atten_o,
  output logic      [7:0]  out_config_o,
  output logic             irq_o
);
  //------------------------------------------------------------
  // Registers
  //------------------------------------------------------------
  logic [7:0]  page_q;
  logic [7:0]  outcfg_q;
  logic [7:0]  stage_q;
  logic [7:0]  pop_q;
  logic [7:0]  power_q;
  logic [15:0] level_q;
  logic [3:0]  irqst_q;
  logic [3:0]  irqmsk_q;
  logic [17:0] tick_cnt_q;
  logic        tick_q;
  logic [3:0]  prot_d;
  logic [3:0]  prot_q;
  logic [3:0]  lat_w;
  logic [3:0]  pwr_w;
  logic [15:0] att_w;
  logic [7:0]  rd_d;
  logic        hit_d;

  wire logic [7:0] idx    = paddr_i[9:2];
  wire logic       access = psel_i & penable_i;
  wire logic       wr     = access & pwrite_i;
  wire logic       rd     = access & ~pwrite_i;
  // (RULE13) other pages hold nothing in this block but the page register
  wire logic       pg0    = (page_q == 8'h00);

  //------------------------------------------------------------
  // Decode helpers
  //------------------------------------------------------------
  function automatic logic is_idx(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  function automatic logic [3:0] clamp(input logic [3:0] v);
    return (v > 4'(opc_pkg::LEVEL_MAX)) ? 4'(opc_pkg::LEVEL_MAX) : v;
  endfunction

  //------------------------------------------------------------
  // Millisecond tick
  //------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tick_cnt_q <= 18'h00000;
      tick_q     <= 1'b0;
    end
    else if (tick_cnt_q == 18'(opc_pkg::TICK_CYC * opc_pkg::STEP_MS - 1))
    begin
      tick_cnt_q <= 18'h00000;
      tick_q     <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 18'h00001;
      tick_q     <= 1'b0;
    end
  end

  //------------------------------------------------------------
  // Register writes
  //------------------------------------------------------------
  // (RULE12) eight-bit registers in the low byte, except the level register, which takes pwdata_i[15:0]
  // (RULE13) page select visible on every page
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      page_q <= opc_pkg::RST_PAGE;
    else if (wr && is_idx(idx, opc_pkg::IDX_PAGE))
      page_q <= pwdata_i[7:0];
  end

  // The stage only copies the type; software writes it before power-up
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      outcfg_q <= opc_pkg::RST_OUTCFG;
    else if (wr && pg0 && is_idx(idx, opc_pkg::IDX_OUTCFG))
      outcfg_q <= pwdata_i[7:0];
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      stage_q <= opc_pkg::RST_STAGE;
    else if (wr && pg0 && is_idx(idx, opc_pkg::IDX_STAGE))
      stage_q <= pwdata_i[7:0];
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pop_q <= opc_pkg::RST_POP;
    else if (wr && pg0 && is_idx(idx, opc_pkg::IDX_POP))
      pop_q <= pwdata_i[7:0];
  end

  // Only four driver bits exist; the upper nibble always reads zero
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      power_q <= opc_pkg::RST_POWER;
    else if (wr && pg0 && is_idx(idx, opc_pkg::IDX_POWER))
      power_q <= {4'h0, pwdata_i[3:0]};
  end

  // (RULE17) level codes above nine dB clamp to nine
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      level_q <= {opc_pkg::RST_LEVEL, opc_pkg::RST_LEVEL};
    else if (wr && pg0 && is_idx(idx, opc_pkg::IDX_LEVEL))
      level_q <= {clamp(pwdata_i[15:12]), clamp(pwdata_i[11:8]),
                  clamp(pwdata_i[7:4]), clamp(pwdata_i[3:0])};
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      irqmsk_q <= opc_pkg::RST_IRQMSK[3:0];
    else if (wr && pg0 && is_idx(idx, opc_pkg::IDX_IRQMSK))
      irqmsk_q <= pwdata_i[3:0];
  end

  //------------------------------------------------------------
  // Read mux
  //------------------------------------------------------------
  always_comb
  begin
    rd_d  = 8'h00;
    hit_d = 1'b1;
    if (is_idx(idx, opc_pkg::IDX_PAGE))
      rd_d = page_q;
    else if (!pg0)
      hit_d = 1'b0;
    else if (is_idx(idx, opc_pkg::IDX_OUTCFG))
      rd_d = outcfg_q;
    else if (is_idx(idx, opc_pkg::IDX_STAGE))
      rd_d = stage_q;
    else if (is_idx(idx, opc_pkg::IDX_POP))
      rd_d = pop_q;
    // (RULE9) live protection and latch per driver
    else if (is_idx(idx, opc_pkg::IDX_SHORT))
      rd_d = {lat_w, prot_d};
    else if (is_idx(idx, opc_pkg::IDX_POWER))
      rd_d = power_q;
    else if (is_idx(idx, opc_pkg::IDX_LEVEL))
      rd_d = level_q[7:0];
    else if (is_idx(idx, opc_pkg::IDX_IRQST))
      rd_d = {4'h0, irqst_q};
    else if (is_idx(idx, opc_pkg::IDX_IRQMSK))
      rd_d = {4'h0, irqmsk_q};
    else if (is_idx(idx, opc_pkg::IDX_PWRST))
      rd_d = {4'h0, pwr_w};
    else
      hit_d = 1'b0;
  end

  //------------------------------------------------------------
  // Bus answer
  //------------------------------------------------------------
  // Answer in the first access cycle; unmapped reads zero with error
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pready_o <= 1'b0;
    else
      pready_o <= psel_i & ~penable_i;
  end

  // Other pages and unmapped indices are refused, index zero excepted
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pslverr_o <= 1'b0;
    else
      pslverr_o <= psel_i & ~penable_i & ~hit_d;
  end

  // Zero on writes and idle cycles so stale data never reaches the bus
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      prdata_o <= 32'h0000_0000;
    else if (psel_i & ~penable_i & ~pwrite_i)
      prdata_o <= {24'h000000, rd_d};
    else
      prdata_o <= 32'h0000_0000;
  end

  //------------------------------------------------------------
  // Sticky interrupt: rising protection, set wins over read-clear
  //------------------------------------------------------------
  wire logic       st_rd  = rd & pready_o & pg0 & is_idx(idx, opc_pkg::IDX_IRQST);
  // A new entry into protection outweighs a clearing read in the same cycle
  wire logic [3:0] irq_nx = (st_rd ? 4'h0 : irqst_q) | (prot_d & ~prot_q);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      prot_q <= 4'h0;
    else
      prot_q <= prot_d;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      irqst_q <= 4'h0;
    else
      irqst_q <= irq_nx;
  end

  // Taken from the next status so the line drops with the clearing read
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(irq_nx & irqmsk_q);
  end

  //------------------------------------------------------------
  // Driver sequencers
  //------------------------------------------------------------
  for (genvar i = 0; i < opc_pkg::NDRV; i++)
  begin : g_drv
    opc_drv_if dif ();
    // (RULE11) power request is software's own bit
    assign dif.power_req = power_q[i];
    // (RULE10) auto shutdown select
    assign dif.auto_off  = stage_q[opc_pkg::STG_AUTO_BIT];
    // (RULE8) soft step on unless disabled
    assign dif.soft_en   = ~stage_q[opc_pkg::STG_SOFT_BIT];
    assign dif.dly_code  = pop_q[opc_pkg::POP_DLY_LSB +: 4];
    assign dif.level     = level_q[4*i +: 4];
    assign dif.tick      = tick_q;
    assign dif.short_det = short_det_i[i];
    assign prot_d[i]     = dif.in_prot;
    assign lat_w[i]      = dif.latched;
    assign pwr_w[i]      = dif.powered;
    assign att_w[4*i +: 4] = dif.atten;
    opc_seq u_seq
    (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d       (dif.seq)
    );
  end

  //------------------------------------------------------------
  // Pin conditions
  //------------------------------------------------------------
  // (RULE6) down condition from pop reduction field
  wire logic [1:0] dn = pop_q[opc_pkg::POP_DN_LSB +: 2];

  // Registered so no decode glitch reaches the analog stage
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      drv_enable_o   <= 4'h0;
      drv_tristate_o <= 4'hF;
      hold_vcm_o     <= 4'h0;
      hold_half_o    <= 4'h0;
    end
    else
    begin
      drv_enable_o   <= pwr_w;
      // (RULE3) tri-state and unpowered when down
      drv_tristate_o <= ~pwr_w & {4{dn == opc_pkg::OPC_DN_TRISTATE}};
      // (RULE4) weak hold at common mode
      hold_vcm_o     <= ~pwr_w & {4{dn == opc_pkg::OPC_DN_VCM}};
      // (RULE5) weak hold at half supply
      hold_half_o    <= ~pwr_w & {4{dn == opc_pkg::OPC_DN_HALF}};
    end
  end

  // (RULE4) reference kept for the common-mode hold, at a cost in standby
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ref_keep_o <= 1'b0;
    else
      ref_keep_o <= (|pwr_w) | (dn == opc_pkg::OPC_DN_VCM);
  end

  // (RULE7) (RULE17) gain and ramp attenuation, four bits per driver
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      drv_gain_o  <= 16'h0000;
      drv_atten_o <= 16'hFFFF;
    end
    else
    begin
      drv_gain_o  <= level_q;
      drv_atten_o <= att_w;
    end
  end

  // (RULE1) configuration passed to power-up scheme
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      out_config_o <= opc_pkg::RST_OUTCFG;
    else
      out_config_o <= outcfg_q;
  end
endmodule
`default_nettype wire

// ===== tb/opc_top_monitor.sv
/*
  Port checker for opc_top: bus answer timing, paged map and pin states.
  Assumes one clock domain and a master that holds each request.
*/
`timescale 1ns/1ps
`default_nettype none
module opc_top_monitor
(
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [3:0]  short_det_i,
  input wire logic [3:0]  drv_enable_o,
  input wire logic [3:0]  drv_tristate_o,
  input wire logic [3:0]  hold_vcm_o,
  input wire logic [3:0]  hold_half_o,
  input wire logic        ref_keep_o,
  input wire logic [15:0] drv_gain_o,
  input wire logic [15:0] drv_atten_o,
  input wire logic [7:0]  out_config_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------
  // Bus answers
  // ----------------------------------------
  setup_answer_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no answer one cycle after setup");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  ready_access_a: assert property (pready_o |-> psel_i && penable_i)
    else $error("ready outside an access cycle");
  err_data_a: assert property (pslverr_o |-> pready_o && prdata_o == 32'h00000000)
    else $error("refused access returned data");
  upper_zero_a: assert property (pready_o |-> prdata_o[31:8] == 24'h000000)
    else $error("read data above bit seven");
  // Page selector is reachable from every page
  page_sel_a: assert property (
    psel_i && penable_i && paddr_i[9:2] == 8'h00 |-> pready_o && !pslverr_o)
    else $error("page selector refused");

  // ----------------------------------------
  // Driver pins
  // ----------------------------------------
  pins_excl_a: assert property (
    ((drv_tristate_o & hold_vcm_o) | (drv_tristate_o & hold_half_o)
     | (hold_vcm_o & hold_half_o)) == 4'h0)
    else $error("two pin conditions at once");
  gain_max_a: assert property (
    drv_gain_o[3:0] <= 4'h9 && drv_gain_o[7:4] <= 4'h9
    && drv_gain_o[11:8] <= 4'h9 && drv_gain_o[15:12] <= 4'h9)
    else $error("output gain above nine");
  rst_state_a: assert property (
    $rose(rst_n_i) |-> drv_tristate_o == 4'hF && drv_enable_o == 4'h0
    && drv_atten_o == 16'hFFFF)
    else $error("wrong pin state out of reset");
endmodule

bind opc_top opc_top_monitor i_mon
(
  .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .short_det_i(short_det_i),
  .drv_enable_o(drv_enable_o), .drv_tristate_o(drv_tristate_o), .hold_vcm_o(hold_vcm_o),
  .hold_half_o(hold_half_o), .ref_keep_o(ref_keep_o), .drv_gain_o(drv_gain_o),
  .drv_atten_o(drv_atten_o), .out_config_o(out_config_o), .irq_o(irq_o)
);
`default_nettype wire

// ===== tb/test_opc_top.sv
/*
  Self-checking bench for opc_top: APB tasks and directed register tests.
  Assumes the 1 ms tick never fires within this short run.
*/
`timescale 1ns/1ps
`default_nettype none
module test_opc_top;
  logic        clk_i, rst_n_i, psel_i, penable_i, pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rdat;
  logic        pready_o, pslverr_o, ref_keep_o, irq_o, rerr;
  logic [3:0]  short_det_i, drv_enable_o, drv_tristate_o, hold_vcm_o, hold_half_o;
  logic [15:0] drv_gain_o, drv_atten_o;
  logic [7:0]  out_config_o;
  logic [7:0]  ridx [6] = '{8'h0E, 8'h28, 8'h2A, 8'h60, 8'h61, 8'h63};
  int          fail_count, check_count;

  opc_top i_dut
  (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .short_det_i(short_det_i),
    .drv_enable_o(drv_enable_o), .drv_tristate_o(drv_tristate_o),
    .hold_vcm_o(hold_vcm_o), .hold_half_o(hold_half_o), .ref_keep_o(ref_keep_o),
    .drv_gain_o(drv_gain_o), .drv_atten_o(drv_atten_o), .out_config_o(out_config_o),
    .irq_o(irq_o)
  );

  always #2 clk_i = ~clk_i;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Read data is taken at the edge where ready is sampled high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= {2'b00, idx, 2'b00};
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i iff pready_o === 1'b1);
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic experr);
    apb(1'b0, idx, 32'h00000000);
    chk("rdata", rdat, exp);
    chk("slverr", 32'(rerr), 32'(experr));
  endtask

  task automatic settle();
    repeat (4) @(posedge clk_i);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Whole run needs fewer than two hundred cycles
  initial
  begin
    #100000;
    fail_count++;
    report_and_stop();
  end

  initial
  begin
    clk_i = 1'b0;
    rst_n_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h00000000;
    short_det_i = 4'h0;
    fail_count = 0;
    check_count = 0;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    settle();
    chk("tristate", 32'(drv_tristate_o), 32'h0000000F);
    chk("atten", 32'(drv_atten_o), 32'h0000FFFF);
    chk("irq", 32'(irq_o), 32'h00000000);
    foreach (ridx[i]) rd(ridx[i], 32'h00000000, 1'b0);
    $display("reset test done");
    wr(8'h0E, 32'hFFFFFFB7);
    rd(8'h0E, 32'h000000B7, 1'b0);
    chk("config", 32'(out_config_o), 32'h000000B7);
    wr(8'h00, 32'h00000001);
    rd(8'h00, 32'h00000001, 1'b0);
    rd(8'h0E, 32'h00000000, 1'b1);
    wr(8'h0E, 32'h00000000);
    wr(8'h00, 32'h00000000);
    rd(8'h0E, 32'h000000B7, 1'b0);
    rd(8'h10, 32'h00000000, 1'b1);
    $display("map test done");
    for (int c = 0; c < 3; c++)
    begin
      wr(8'h2A, 32'(c << 2));
      settle();
      chk("tristate", 32'(drv_tristate_o), 32'({4{c == 0}}));
      chk("vcm", 32'(hold_vcm_o), 32'({4{c == 1}}));
      chk("refkeep", 32'(ref_keep_o), 32'(c == 1));
      chk("half", 32'(hold_half_o), 32'({4{c == 2}}));
    end
    $display("pin test done");
    wr(8'h2A, 32'h00000000);
    wr(8'h60, 32'h00000001);
    settle();
    chk("enable", 32'(drv_enable_o), 32'h00000001);
    chk("tristate", 32'(drv_tristate_o), 32'h0000000E);
    chk("atten", 32'(drv_atten_o[3:0]), 32'h0000000F);
    wr(8'h28, 32'h00000001);
    wr(8'h60, 32'h00000003);
    settle();
    chk("enable", 32'(drv_enable_o), 32'h00000003);
    chk("atten", 32'(drv_atten_o[7:4]), 32'h00000000);
    wr(8'h61, 32'h0000C395);
    rd(8'h61, 32'h00000095, 1'b0);
    chk("gain", 32'(drv_gain_o), 32'h00009395);
    $display("power test done");
    wr(8'h60, 32'h0000000F);
    short_det_i <= 4'h1;
    settle();
    chk("enable", 32'(drv_enable_o), 32'h0000000F);
    rd(8'h5F, 32'h00000001, 1'b0);
    chk("irq", 32'(irq_o), 32'h00000000);
    wr(8'h63, 32'h00000001);
    settle();
    chk("irq", 32'(irq_o), 32'h00000001);
    rd(8'h62, 32'h00000001, 1'b0);
    settle();
    chk("irq", 32'(irq_o), 32'h00000000);
    short_det_i <= 4'h0;
    $display("limit test done");
    wr(8'h28, 32'h00000003);
    short_det_i <= 4'h2;
    settle();
    chk("enable", 32'(drv_enable_o), 32'h0000000D);
    short_det_i <= 4'h0;
    settle();
    rd(8'h5F, 32'h00000020, 1'b0);
    chk("enable", 32'(drv_enable_o), 32'h0000000D);
    wr(8'h60, 32'h0000000D);
    wr(8'h2A, 32'h00000010);
    wr(8'h60, 32'h0000000F);
    settle();
    chk("enable", 32'(drv_enable_o), 32'h0000000F);
    chk("atten", 32'(drv_atten_o[7:4]), 32'h0000000F);
    rd(8'h5F, 32'h00000000, 1'b0);
    $display("shutdown test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
